//--- hdl/lcs_pkg.sv
// Package with constants and types for the LCD cascade sync block.
package lcs_pkg;
  // Cascade addressing.
  localparam int SUBADDR_W = 3;
  localparam int POS_W = 4;
  localparam int NUM_POS = 16;
  // Slave address byte layout: fixed upper bits, cluster bit at 1, R/W at 0.
  localparam logic [5:0] SLAVE_ADDR_FIXED = 6'h1C;
  localparam int ADDR_SEL_BIT = 1;
  localparam int ADDR_RW_BIT = 0;
  // Backplane sequencing.
  localparam int BP_NUM = 4;
  localparam int SLOT_W = 2;
  // Clock timing: 40 MHz system clock.
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  // Minimum sync low time in ns, and its cycle count rounded up.
  localparam int SYNC_LOW_NS = 1000;
  localparam int SYNC_LOW_CYC = (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SYNC_LOW_CYC_V = 8'(SYNC_LOW_CYC);
  // Multiplex mode: number of active backplanes minus one.
  typedef enum logic [1:0] {LCS_MUX_STATIC, LCS_MUX_2, LCS_MUX_3, LCS_MUX_4} lcs_mux_t;
  // Slot stepping states.
  typedef enum logic [1:0] {LCS_IDLE, LCS_RUN, LCS_HOLD} lcs_state_t;
endpackage

//--- hdl/lcs_sync2.sv
// Two flip-flop synchroniser for a single pin level.
`timescale 1ns/1ps
module lcs_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Level in and out.
  input wire logic d,
  output logic q
);
  logic meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- hdl/lcs_cascade_sync.sv
// Cascade addressing and backplane frame synchronisation for an LCD driver.
// What this block does
// - Cascade position is cluster select times eight plus the 3-bit hardware subaddress.
// - Sync line is active low open-drain; only pulls low, pull-up restores high.
// - Pull sync low when the last active backplane slot begins; otherwise only watch.
// - First device asserting sync wins; watchers realign their slot sequence to it.
// - After power-on reset every device starts its frame at slot zero, aligned.
// - Clock source select high disables the oscillator; clock pin becomes an input.
// - Acknowledge slave address only when its select bit equals cluster select.
// - Acknowledge display bytes only when subaddress counter equals pins.
`timescale 1ns/1ps
module lcs_cascade_sync
  import lcs_pkg::*;
#(
  parameter int BP_N = BP_NUM
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Address pins.
  input wire logic CLUSTER_SELECT,
  input wire logic HW_SUBADDRESS_BIT0,
  input wire logic HW_SUBADDRESS_BIT1,
  input wire logic HW_SUBADDRESS_BIT2,
  // Clock source select and display clock pin.
  input wire logic CLK_SRC_SEL,
  input wire logic DISP_CLK_I,
  input wire logic OSC_TICK,
  output logic DISP_CLK_O,
  output logic DISP_CLK_OE_B,
  // Cascade sync pin.
  input wire logic SYNC_B_I,
  output logic SYNC_B_O,
  output logic SYNC_B_OE_B,
  // Multiplex mode from the command decoder.
  input wire lcs_pkg::lcs_mux_t MUX_MODE,
  // Address matching from the bus controller.
  input wire logic [7:0] ADDR_BYTE,
  input wire logic ADDR_VALID,
  input wire logic [2:0] SUBADDR_CNT,
  input wire logic DATA_PHASE,
  // Outputs.
  output logic [3:0] CASCADE_POS,
  output logic ADDR_ACK,
  output logic DATA_ACK,
  output logic [BP_N-1:0] BACKPLANE_OUTPUTS,
  output logic [1:0] SLOT
);
  import lcs_pkg::*;

  logic sel_s, a0_s, a1_s, a2_s, src_s, dclk_s, sync_s;
  logic dclk_prev_q, sync_prev_q;
  logic [SLOT_W-1:0] slot_q;
  logic drive_q;
  logic [7:0] low_cnt_q;
  logic [7:0] low_seen_q;
  lcs_state_t state_q;
  logic tick, sync_fall, last_slot;

  // Every pin level passes two flip-flops before any logic reads it.
  lcs_sync2 #(.RESET_VAL(1'b0)) u_sel (.clk(CLK), .rst_b(RST_B), .d(CLUSTER_SELECT), .q(sel_s));
  lcs_sync2 #(.RESET_VAL(1'b0)) u_a0 (.clk(CLK), .rst_b(RST_B), .d(HW_SUBADDRESS_BIT0), .q(a0_s));
  lcs_sync2 #(.RESET_VAL(1'b0)) u_a1 (.clk(CLK), .rst_b(RST_B), .d(HW_SUBADDRESS_BIT1), .q(a1_s));
  lcs_sync2 #(.RESET_VAL(1'b0)) u_a2 (.clk(CLK), .rst_b(RST_B), .d(HW_SUBADDRESS_BIT2), .q(a2_s));
  lcs_sync2 #(.RESET_VAL(1'b0)) u_src (.clk(CLK), .rst_b(RST_B), .d(CLK_SRC_SEL), .q(src_s));
  lcs_sync2 #(.RESET_VAL(1'b0)) u_dclk (.clk(CLK), .rst_b(RST_B), .d(DISP_CLK_I), .q(dclk_s));
  lcs_sync2 #(.RESET_VAL(1'b1)) u_sync (.clk(CLK), .rst_b(RST_B), .d(SYNC_B_I), .q(sync_s));

  // Position and address matching.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      CASCADE_POS <= 4'h0;
      ADDR_ACK <= 1'b0;
      DATA_ACK <= 1'b0;
    end
    else
    begin
      CASCADE_POS <= {sel_s, a2_s, a1_s, a0_s};
      ADDR_ACK <= ADDR_VALID && (ADDR_BYTE[7:2] == SLAVE_ADDR_FIXED)
                  && (ADDR_BYTE[ADDR_SEL_BIT] == sel_s) && !ADDR_BYTE[ADDR_RW_BIT];
      DATA_ACK <= DATA_PHASE && (SUBADDR_CNT == {a2_s, a1_s, a0_s});
    end
  end

  // Display clock source: oscillator driven out unless an external clock is selected.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      DISP_CLK_O <= 1'b0;
      dclk_prev_q <= 1'b0;
      sync_prev_q <= 1'b1;
    end
    else
    begin
      DISP_CLK_O <= src_s ? 1'b0 : (DISP_CLK_O ^ OSC_TICK);
      dclk_prev_q <= dclk_s;
      sync_prev_q <= sync_s;
    end
  end

  // The pin is an output only in oscillator mode.
  assign DISP_CLK_OE_B = src_s;
  assign tick = src_s ? (dclk_s && !dclk_prev_q) : OSC_TICK;
  assign sync_fall = sync_prev_q && !sync_s;
  assign last_slot = (slot_q == SLOT_W'(MUX_MODE));

  // Slot sequencing and realignment on a foreign sync edge.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      slot_q <= '0;
      state_q <= LCS_IDLE;
    end
    else
    begin
      case (state_q)
        LCS_IDLE: state_q <= LCS_RUN;
        LCS_RUN:
        begin
          if (sync_fall && !drive_q)
          begin
            slot_q <= SLOT_W'(MUX_MODE);
            state_q <= LCS_HOLD;
          end
          else if (tick)
          begin
            slot_q <= last_slot ? '0 : slot_q + 1'b1;
          end
        end
        LCS_HOLD:
        begin
          if (tick)
          begin
            slot_q <= '0;
            state_q <= LCS_RUN;
          end
        end
        default: state_q <= LCS_IDLE;
      endcase
    end
  end

  // Sync drive during the last active slot, held at least the minimum low time.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      drive_q <= 1'b0;
      low_cnt_q <= 8'h00;
    end
    else if (state_q == LCS_RUN && last_slot)
    begin
      drive_q <= 1'b1;
      low_cnt_q <= (low_cnt_q == SYNC_LOW_CYC_V) ? low_cnt_q : low_cnt_q + 8'h01;
    end
    else if (drive_q && low_cnt_q < SYNC_LOW_CYC_V)
    begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
    else
    begin
      drive_q <= 1'b0;
      low_cnt_q <= 8'h00;
    end
  end

  // Open drain: the output level is always low, enable active low.
  assign SYNC_B_O = 1'b0;
  assign SYNC_B_OE_B = !drive_q;
  assign SLOT = slot_q;

  // Backplane slot one-hot.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      BACKPLANE_OUTPUTS <= '0;
    else
      BACKPLANE_OUTPUTS <= BP_N'(1) << slot_q;
  end

  // Counts the cycles that our own output has held the sync wire low, for the low-time check.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      low_seen_q <= 8'h00;
    else if (SYNC_B_OE_B)
      low_seen_q <= 8'h00;
    else if (low_seen_q != 8'hFF)
      low_seen_q <= low_seen_q + 8'h01;
  end

  // Checks on sync drive, realignment, addressing and the clock source.
  drive_last_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (state_q == LCS_RUN && last_slot) |=> !SYNC_B_OE_B) else $error("sync not driven");
  drive_only_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(SYNC_B_OE_B) |-> $past(last_slot)) else $error("sync driven off slot");
  od_low_a: assert property (@(posedge CLK) disable iff (!RST_B)
    SYNC_B_O == 1'b0) else $error("sync drives high");
  min_low_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(SYNC_B_OE_B) |-> !SYNC_B_OE_B [*8]) else $error("sync low too short");
  low_time_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(SYNC_B_OE_B) |-> $past(low_seen_q) >= SYNC_LOW_CYC_V - 8'h01)
    else $error("sync released before minimum low time");
  realign_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (state_q == LCS_RUN && sync_fall && !drive_q) |=> slot_q == SLOT_W'(MUX_MODE))
    else $error("no realign");
  pos_a: assert property (@(posedge CLK) disable iff (!RST_B)
    CASCADE_POS == $past({sel_s, a2_s, a1_s, a0_s})) else $error("bad position");
  addr_a: assert property (@(posedge CLK) disable iff (!RST_B)
    ADDR_ACK |-> $past(ADDR_VALID && ADDR_BYTE[ADDR_SEL_BIT] == sel_s
    && !ADDR_BYTE[ADDR_RW_BIT])) else $error("bad addr ack");
  data_a: assert property (@(posedge CLK) disable iff (!RST_B)
    DATA_ACK |-> $past(SUBADDR_CNT == {a2_s, a1_s, a0_s})) else $error("bad data ack");
  ext_clk_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (src_s && $past(src_s)) |-> (DISP_CLK_OE_B && !DISP_CLK_O))
    else $error("clk driven in ext mode");
  ext_step_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (state_q == LCS_RUN && src_s && dclk_s && !dclk_prev_q && !sync_fall && !last_slot)
    |=> slot_q == $past(slot_q) + 2'h1) else $error("pin clock edge not taken");
  osc_off_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (state_q == LCS_RUN && src_s && OSC_TICK && !(dclk_s && !dclk_prev_q) && !sync_fall)
    |=> $stable(slot_q)) else $error("oscillator tick taken in ext mode");
endmodule

//--- bench/lcs_peer.sv
// Model of a second cascaded driver that shares the sync wire.
`timescale 1ns/1ps
module lcs_peer
  import lcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Request to assert sync, and the open-drain enable.
  input wire logic pull,
  output logic oe_b
);
  logic [7:0] cnt_q;
  // Pull low only, for the minimum low time; otherwise let the pull-up win.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= 8'h00;
    else if (pull)
      cnt_q <= SYNC_LOW_CYC_V;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign oe_b = (cnt_q == 8'h00);
endmodule

//--- bench/lcs_cascade_sync_tb_top.sv
// Self-checking bench for the cascade addressing and sync block.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module lcs_cascade_sync_tb_top;
  import lcs_pkg::*;
  logic clk = 0, rst_b = 0, sel = 0, tick = 0, av = 0, dp = 0, pull = 0, src = 0, dclk = 0;
  lcs_mux_t mux = LCS_MUX_4;
  logic [2:0] a = 0, cnt = 0;
  logic [7:0] ab = 0;
  logic oe_b, peer_oe_b, ack, dack, dco, dcoe, so;
  logic [3:0] pos, bp;
  logic [1:0] slot;
  int n_fail = 0, comparisons = 0, cyc = 0;
  // The wire is pulled up unless one party pulls it low.
  wire logic sync_w = oe_b & peer_oe_b;
  // Clock source select, clock pin and multiplex mode are set by the scenarios.
  lcs_cascade_sync i_lcs_cascade_sync (.CLK(clk), .RST_B(rst_b), .CLUSTER_SELECT(sel),
    .HW_SUBADDRESS_BIT0(a[0]), .HW_SUBADDRESS_BIT1(a[1]), .HW_SUBADDRESS_BIT2(a[2]),
    .CLK_SRC_SEL(src), .DISP_CLK_I(dclk), .OSC_TICK(tick), .DISP_CLK_O(dco),
    .DISP_CLK_OE_B(dcoe), .SYNC_B_I(sync_w), .SYNC_B_O(so), .SYNC_B_OE_B(oe_b),
    .MUX_MODE(mux), .ADDR_BYTE(ab), .ADDR_VALID(av), .SUBADDR_CNT(cnt),
    .DATA_PHASE(dp), .CASCADE_POS(pos), .ADDR_ACK(ack), .DATA_ACK(dack),
    .BACKPLANE_OUTPUTS(bp), .SLOT(slot));
  lcs_peer i_lcs_peer (.clk(clk), .rst_b(rst_b), .pull(pull), .oe_b(peer_oe_b));
  // Clock at 40 MHz.
  initial forever #12.5 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic osc_tick();
    tick = 1;
    step(1);
    tick = 0;
    step(49);
  endtask
  // In external mode the bench is the only clock source: one rising edge on the clock pin.
  task automatic pin_edge();
    dclk = 1;
    step(25);
    dclk = 0;
    step(25);
  endtask
  // Position and slave address matching for both clusters.
  task automatic t_addr();
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      a = 3'h5;
      step(4);
      `CHK(pos, 4'(s * 8 + 5))
      for (int b = 0; b < 3; b++)
      begin
        ab = {SLAVE_ADDR_FIXED, b[0], b[1]};
        av = 1;
        step(1);
        av = 0;
        `CHK(ack, (b[0] == s[0]) && !b[1])
        step(1);
        `CHK(ack, 1'b0)
      end
      ab = {SLAVE_ADDR_FIXED ^ 6'h01, s[0], 1'b0};
      av = 1;
      step(1);
      av = 0;
      `CHK(ack, 1'b0)
    end
  endtask
  // Display byte acknowledge follows the subaddress counter.
  task automatic t_data();
    dp = 1;
    cnt = 3'h5;
    step(2);
    `CHK(dack, 1'b1)
    cnt = 3'h4;
    step(2);
    `CHK(dack, 1'b0)
    dp = 0;
    cnt = 3'h5;
    step(2);
    `CHK(dack, 1'b0)
  endtask
  // One full frame: pull low in the last slot, release on wrap.
  task automatic t_frame();
    `CHK(slot, 2'h0)
    `CHK(dcoe, 1'b0)
    `CHK(so, 1'b0)
    repeat (2) osc_tick();
    `CHK(oe_b, 1'b1)
    osc_tick();
    `CHK(dco, 1'b1)
    `CHK(slot, 2'h3)
    `CHK(bp, 4'h8)
    `CHK(oe_b, 1'b0)
    osc_tick();
    `CHK(slot, 2'h0)
    `CHK(oe_b, 1'b1)
  endtask
  // A peer asserts first: this device jumps to its last slot.
  task automatic t_realign();
    pull = 1;
    step(1);
    pull = 0;
    step(6);
    `CHK(slot, 2'h3)
    `CHK(oe_b, 1'b1)
    step(50);
    osc_tick();
    `CHK(slot, 2'h0)
  endtask
  // External clock in two-backplane mode: oscillator ignored, slots step on the pin.
  task automatic t_ext();
    src = 1;
    mux = LCS_MUX_2;
    step(3);
    `CHK(dcoe, 1'b1)
    `CHK(dco, 1'b0)
    osc_tick();
    `CHK(slot, 2'h0)
    pin_edge();
    `CHK(slot, 2'h1)
    `CHK(bp, 4'h2)
    `CHK(oe_b, 1'b0)
    pin_edge();
    `CHK(slot, 2'h0)
    `CHK(oe_b, 1'b1)
    src = 0;
    mux = LCS_MUX_4;
    step(3);
    `CHK(dcoe, 1'b0)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycle ceiling against hangs.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out();
    end
  end
  // Main sequence.
  initial
  begin
    step(20);
    rst_b = 1;
    step(3);
    t_frame();
    t_realign();
    t_ext();
    t_addr();
    t_data();
    close_out();
  end
endmodule
